/* test_timer2_waveform_modes.sv */
// Self-checking bench for the waveform timer
`timescale 1ns/1ns
`default_nettype none
module test_timer2_waveform_modes;
    import tmw_pkg::*;
    logic        clock = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        cmp_ack = 0, ovf_ack = 0, port_data = 0, port_dir = 0;
    logic        pready, pslverr, pin_out, pin_oe, cmp_flag, ovf_flag, cmp_state;
    logic [32:0] exp_q[$];
    int          mismatches = 0, checks_done = 0, seed = 8;
    int tc[10][5] = '{
        '{3, 2, 100, 101, 155},
        '{3, 3, 100, 155, 101},
        '{3, 2, 0, 1, 255},
        '{3, 1, 20, 256, 256},
        '{3, 2, 255, -1, 1},
        '{3, 3, 255, -1, 0},
        '{1, 2, 64, 128, 382},
        '{1, 3, 64, 382, 128},
        '{1, 2, 0, -1, 0},
        '{1, 3, 255, -1, 0}};
    always #2 clock = ~clock;
    tmw_timer #(.PRESCALE_W(10)) DUT (.I_CLOCK(clock), .I_RESET(reset), .I_PSEL(psel),
        .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .I_COMPARE_ACK(cmp_ack), .I_OVERFLOW_ACK(ovf_ack), .I_PORT_DATA(port_data),
        .I_PORT_DIR(port_dir), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .O_PIN_OUT(pin_out), .O_PIN_OE(pin_oe), .O_COMPARE_FLAG(cmp_flag),
        .O_OVERFLOW_FLAG(ovf_flag), .O_COMPARE_STATE(cmp_state));
    // ************
    // Bus and compare tasks
    // ************
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic cmp_val(input logic [32:0] got, input logic [32:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_len(input int got, input int exp);
        checks_done++;
        if (got != exp) begin
            mismatches++;
            $display("mismatch at %0t: length %0d expected %0d", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1;
        do @(posedge clock); while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(0, a, 32'h0);
    endtask
    always @(posedge clock) begin
        if (psel && penable && !pwrite && pready === 1'b1) begin
            cmp_val({pslverr, prdata}, exp_q.pop_front());
        end
    end
    task automatic cfg(input logic [1:0] m, input logic [1:0] cm, input logic [2:0] cs,
                       input logic [7:0] c);
        wr(OFF_COMPARE, {24'h0, c});
        wr(OFF_CONTROL, {25'h0, cs, cm, m});
        repeat (600) @(posedge clock);
    endtask
    task automatic pulse(input int hi_e, input int lo_e);
        int hi, lo, n;
        hi = 0; lo = 0; n = 0;
        while (pin_out !== 1'b0 && n < 2000) begin @(negedge clock); n++; end
        while (pin_out !== 1'b1 && n < 4000) begin @(negedge clock); n++; end
        while (pin_out === 1'b1 && hi < 2000) begin @(negedge clock); hi++; end
        while (pin_out === 1'b0 && lo < 2000) begin @(negedge clock); lo++; end
        cmp_len(hi, hi_e);
        cmp_len(lo, lo_e);
    endtask
    task automatic steady(input logic v);
        int bad;
        bad = 0;
        repeat (600) begin @(negedge clock); if (pin_out !== v) bad++; end
        cmp_len(bad, 0);
    endtask
    task automatic first_change(input int lo, input int hi);
        logic s;
        int   n;
        s = cmp_state; n = 0;
        while (cmp_state === s && n < 1000) begin @(negedge clock); n++; end
        cmp_len(int'(n > lo && n < hi), 1);
    endtask
    // ************
    // Main sequence
    // ************
    initial begin
        logic [7:0] c;
        repeat (4) @(posedge clock);
        reset <= 0;
        for (int a = 0; a <= 16; a += 4) rd(8'(a), 33'h0);
        rd(8'h14, {1'b1, 32'h0});
        wr(OFF_COUNT, 32'h37);
        repeat (20) @(posedge clock);
        rd(OFF_COUNT, 33'h37);
        wr(OFF_CONTROL, {25'h0, 3'h1, COM_OFF, WGM_MATCH});
        repeat (40) begin @(posedge clock); port_data <= 1'($random(seed)); port_dir <= 1'($random(seed)); end
        @(posedge clock);
        port_dir <= 1;
        wr(OFF_CONTROL, {25'h0, 3'h0, COM_TOGGLE, WGM_MATCH});
        wr(OFF_COMPARE, 32'h5);
        wr(OFF_COUNT, 32'h5);
        wr(OFF_CONTROL, {25'h0, 3'h1, COM_TOGGLE, WGM_MATCH});
        first_change(240, 270);
        pulse(6, 6);
        wr(OFF_CONTROL, {25'h0, 3'h0, COM_TOGGLE, WGM_MATCH});
        wr(OFF_COUNT, 32'd50);
        wr(OFF_COMPARE, 32'd10);
        wr(OFF_CONTROL, {25'h0, 3'h1, COM_TOGGLE, WGM_MATCH});
        first_change(200, 235);
        c = 8'($random(seed)) & 8'h07;
        cfg(WGM_MATCH, COM_TOGGLE, 3'h2, c);
        pulse(8 * (c + 1), 8 * (c + 1));
        for (int i = 0; i < 10; i++) begin
            cfg(2'(tc[i][0]), 2'(tc[i][1]), 3'h1, 8'(tc[i][2]));
            if (tc[i][3] < 0) steady(1'(tc[i][4]));
            else pulse(tc[i][3], tc[i][4]);
        end
        cfg(WGM_FAST, COM_CLEAR, 3'h1, 8'd100);
        wr(OFF_CONTROL, {25'h0, 3'h0, COM_CLEAR, WGM_FAST});
        rd(OFF_FLAGS, 33'h3);
        wr(OFF_FLAGS, 32'h2);
        rd(OFF_FLAGS, 33'h1);
        cmp_ack <= 1;
        ovf_ack <= 1;
        @(posedge clock);
        cmp_ack <= 0;
        ovf_ack <= 0;
        rd(OFF_FLAGS, 33'h0);
        @(negedge clock);
        cmp_val({30'h0, cmp_flag, ovf_flag, pin_oe}, 33'h1);
        repeat (4) @(posedge clock);
        end_of_test();
    end
    initial begin
        #400000;
        mismatches++;
        end_of_test();
    end
endmodule
`default_nettype wire

/* tmw_pkg.sv */
// Shared constants for the 8-bit waveform timer
package tmw_pkg;

    // ********************************************************
    // Bus geometry, count and prescaler widths
    // ********************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W  = 8;
    localparam int PRE_W  = 10;

    // ********************************************************
    // Register byte offsets
    // ********************************************************
    localparam logic [ADDR_W-1:0] OFF_CONTROL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_COUNT   = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_COMPARE = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_FLAGS   = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_STATUS  = 8'h10;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int CTL_MODE_LSB  = 0;
    localparam int CTL_COM_LSB   = 2;
    localparam int CTL_CS_LSB    = 4;
    localparam int CTL_FORCE_BIT = 7;
    localparam int FLG_CMP_BIT   = 0;
    localparam int FLG_OVF_BIT   = 1;
    localparam int STA_OCS_BIT   = 0;
    localparam int STA_DOWN_BIT  = 1;

    // ********************************************************
    // Mode and compare output codes
    // ********************************************************
    localparam logic [1:0] WGM_NORMAL = 2'h0;
    localparam logic [1:0] WGM_PHASE  = 2'h1;
    localparam logic [1:0] WGM_MATCH  = 2'h2;
    localparam logic [1:0] WGM_FAST   = 2'h3;
    localparam logic [1:0] COM_OFF    = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR  = 2'h2;
    localparam logic [1:0] COM_SET    = 2'h3;

    // ********************************************************
    // Count limits and reset values
    // ********************************************************
    localparam logic [CNT_W-1:0] CNT_MAX    = 8'hff;
    localparam logic [CNT_W-1:0] CNT_BOTTOM = 8'h00;
    localparam logic [CNT_W-1:0] RST_COUNT  = 8'h00;
    localparam logic [CNT_W-1:0] RST_OCR    = 8'h00;
    localparam logic [2:0]       RST_CS     = 3'h0;

endpackage

/* tmw_timer.sv */
// 8-bit timer with one compare channel, waveform modes and an APB slave
`timescale 1ns/1ns
`default_nettype none

module tmw_timer
    import tmw_pkg::*;
#(
    parameter int PRESCALE_W = tmw_pkg::PRE_W
) (
    input  wire logic                        I_CLOCK,
    input  wire logic                        I_RESET,
    input  wire logic                        I_PSEL,
    input  wire logic                        I_PENABLE,
    input  wire logic                        I_PWRITE,
    input  wire logic [tmw_pkg::ADDR_W-1:0]  I_PADDR,
    input  wire logic [tmw_pkg::DATA_W-1:0]  I_PWDATA,
    input  wire logic                        I_COMPARE_ACK,
    input  wire logic                        I_OVERFLOW_ACK,
    input  wire logic                        I_PORT_DATA,
    input  wire logic                        I_PORT_DIR,
    output logic [tmw_pkg::DATA_W-1:0]       O_PRDATA,
    output logic                             O_PREADY,
    output logic                             O_PSLVERR,
    output logic                             O_PIN_OUT,
    output logic                             O_PIN_OE,
    output logic                             O_COMPARE_FLAG,
    output logic                             O_OVERFLOW_FLAG,
    output logic                             O_COMPARE_STATE
);
    import tmw_pkg::*;

    // ********************************************************
    // Elaboration check
    // ********************************************************
    if (PRESCALE_W != PRE_W) begin : g_bad_prescale
        $error("Prescaler width must equal the largest division step");
    end

    // Count width is fixed by the 8-bit resolution of the waveform modes
    if (CNT_W != 8) begin : g_bad_count
        $error("Count width must be eight bits");
    end

    // ********************************************************
    // State
    // ********************************************************
    typedef struct packed {
        logic [CNT_W-1:0]      count;
        logic [CNT_W-1:0]      ocr_act;
        logic [CNT_W-1:0]      ocr_buf;
        logic [1:0]            mode;
        logic [1:0]            com;
        logic [2:0]            cs;
        logic                  ocs;
        logic                  down;
        logic                  block;
        logic                  cmf;
        logic                  ovf;
        logic [PRESCALE_W-1:0] presc;
        logic [DATA_W-1:0]     rdata;
    } tmw_state_t;

    tmw_state_t st;
    tmw_state_t next_st;

    // ********************************************************
    // Helpers
    // ********************************************************
    // Tick strobe for division 1, 8, 32, 64, 128, 256, 1024; 0 stops
    function automatic logic presc_tick(input logic [2:0] cs,
                                        input logic [PRESCALE_W-1:0] p);
        logic t;
        t = 1'b0;
        case (cs)
            3'h1: t = 1'b1;
            3'h2: t = &p[2:0];
            3'h3: t = &p[4:0];
            3'h4: t = &p[5:0];
            3'h5: t = &p[6:0];
            3'h6: t = &p[7:0];
            3'h7: t = &p[9:0];
            default: t = 1'b0;
        endcase
        return t;
    endfunction

    // Non-PWM action on a match or a forced match
    function automatic logic com_action(input logic [1:0] com, input logic ocs);
        logic r;
        r = ocs;
        case (com)
            COM_TOGGLE: r = ~ocs;
            COM_CLEAR:  r = 1'b0;
            COM_SET:    r = 1'b1;
            default:    r = ocs;
        endcase
        return r;
    endfunction

    function automatic logic addr_known(input logic [ADDR_W-1:0] a);
        return (a == OFF_CONTROL) || (a == OFF_COUNT) || (a == OFF_COMPARE) ||
               (a == OFF_FLAGS) || (a == OFF_STATUS);
    endfunction

    // ********************************************************
    // Next state
    // ********************************************************
    logic tick;
    logic hit;
    logic pwm;
    logic wr;
    logic rd_setup;
    logic ovf_set;

    always_comb begin
        next_st       = st;
        next_st.presc = st.presc + 1'b1;
        tick          = presc_tick(st.cs, st.presc);
        hit           = (st.count == st.ocr_act) && !st.block;
        pwm           = (st.mode == WGM_FAST) || (st.mode == WGM_PHASE);
        wr            = I_PSEL && I_PENABLE && I_PWRITE;
        rd_setup      = I_PSEL && !I_PENABLE && !I_PWRITE;
        ovf_set       = 1'b0;
        // Overflow sets below are collected on a cleared copy
        next_st.ovf   = 1'b0;

        if (tick) begin
            next_st.block = 1'b0;
            if (hit) begin
                next_st.cmf = 1'b1;
            end
            case (st.mode)
                WGM_MATCH: begin
                    if (hit) begin
                        next_st.count = CNT_BOTTOM;
                        next_st.ocs   = com_action(st.com, st.ocs);
                    end else begin
                        next_st.count = st.count + 1'b1;
                    end
                    if (st.count == CNT_MAX) begin
                        next_st.ovf = 1'b1;
                    end
                end
                WGM_FAST: begin
                    if (hit) begin
                        if (st.com == COM_TOGGLE) begin
                            next_st.ocs = ~st.ocs;
                        end else if (st.com[1]) begin
                            next_st.ocs = st.com[0];
                        end
                    end
                    if (st.count == CNT_MAX) begin
                        next_st.count   = CNT_BOTTOM;
                        next_st.ovf     = 1'b1;
                        next_st.ocr_act = st.ocr_buf;
                        // Bottom wins over a match at maximum
                        if (st.com[1]) begin
                            next_st.ocs = ~st.com[0];
                        end
                    end else begin
                        next_st.count = st.count + 1'b1;
                    end
                end
                WGM_PHASE: begin
                    if (st.count == CNT_MAX) begin
                        next_st.down    = 1'b1;
                        next_st.count   = CNT_MAX - 1'b1;
                        next_st.ocr_act = st.ocr_buf;
                        if (st.com[1]) begin
                            // Maximum compare forces the down-match level; else force up-match level
                            next_st.ocs = (st.ocr_buf == CNT_MAX) ^ st.com[0];
                        end
                    end else if (!st.down || (st.count == CNT_BOTTOM)) begin
                        next_st.down  = 1'b0;
                        next_st.count = st.count + 1'b1;
                        if (hit && st.com[1]) begin
                            next_st.ocs = st.com[0];
                        end
                    end else begin
                        next_st.count = st.count - 1'b1;
                        if (st.count == CNT_BOTTOM + 1'b1) begin
                            next_st.ovf = 1'b1;
                        end
                        if (hit && st.com[1]) begin
                            next_st.ocs = ~st.com[0];
                        end
                    end
                end
                default: begin
                    next_st.count = st.count + 1'b1;
                    if (st.count == CNT_MAX) begin
                        next_st.ovf = 1'b1;
                    end
                    if (hit) begin
                        next_st.ocs = com_action(st.com, st.ocs);
                    end
                end
            endcase
        end


        // Sticky flag; a set in this cycle beats any clear below
        ovf_set     = next_st.ovf;
        next_st.ovf = st.ovf | ovf_set;

        // Software flag clears; a same-cycle set survives
        if (I_COMPARE_ACK && !(tick && hit)) begin
            next_st.cmf = 1'b0;
        end
        if (I_OVERFLOW_ACK && !ovf_set) begin
            next_st.ovf = 1'b0;
        end

        if (wr) begin
            case (I_PADDR)
                OFF_CONTROL: begin
                    next_st.mode = I_PWDATA[CTL_MODE_LSB +: 2];
                    next_st.com  = I_PWDATA[CTL_COM_LSB +: 2];
                    next_st.cs   = I_PWDATA[CTL_CS_LSB +: 3];
                    next_st.down = 1'b0;
                    // Forced match: output only, no flag, no clear
                    if (I_PWDATA[CTL_FORCE_BIT] && !pwm) begin
                        next_st.ocs = com_action(I_PWDATA[CTL_COM_LSB +: 2], st.ocs);
                    end
                end
                OFF_COUNT: begin
                    next_st.count = I_PWDATA[CNT_W-1:0];
                    next_st.block = 1'b1;
                end
                OFF_COMPARE: begin
                    next_st.ocr_buf = I_PWDATA[CNT_W-1:0];
                    if (!pwm) begin
                        next_st.ocr_act = I_PWDATA[CNT_W-1:0];
                    end
                end
                OFF_FLAGS: begin
                    if (I_PWDATA[FLG_CMP_BIT] && !(tick && hit)) begin
                        next_st.cmf = 1'b0;
                    end
                    if (I_PWDATA[FLG_OVF_BIT] && !ovf_set) begin
                        next_st.ovf = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // Read data is latched in the setup phase
        if (rd_setup) begin
            next_st.rdata = '0;
            case (I_PADDR)
                OFF_CONTROL: begin
                    next_st.rdata[CTL_MODE_LSB +: 2] = st.mode;
                    next_st.rdata[CTL_COM_LSB +: 2]  = st.com;
                    next_st.rdata[CTL_CS_LSB +: 3]   = st.cs;
                end
                OFF_COUNT: begin
                    next_st.rdata[CNT_W-1:0] = st.count;
                end
                // Buffer equals the active value after a compare write outside the PWM modes
                OFF_COMPARE: begin
                    next_st.rdata[CNT_W-1:0] = st.ocr_buf;
                end
                OFF_FLAGS: begin
                    next_st.rdata[FLG_CMP_BIT] = st.cmf;
                    next_st.rdata[FLG_OVF_BIT] = st.ovf;
                end
                OFF_STATUS: begin
                    next_st.rdata[STA_OCS_BIT]  = st.ocs;
                    next_st.rdata[STA_DOWN_BIT] = st.down;
                end
                default: begin
                    next_st.rdata = '0;
                end
            endcase
        end
    end

    // ********************************************************
    // Registers
    // ********************************************************
    always_ff @(posedge I_CLOCK) begin
        if (I_RESET) begin
            st         <= '0;
            st.count   <= RST_COUNT;
            st.ocr_act <= RST_OCR;
            st.ocr_buf <= RST_OCR;
            st.mode    <= WGM_NORMAL;
            st.com     <= COM_OFF;
            st.cs      <= RST_CS;
        end else begin
            st <= next_st;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    assign O_PRDATA        = st.rdata;
    assign O_PREADY        = 1'b1;
    assign O_PSLVERR       = I_PSEL && I_PENABLE && !addr_known(I_PADDR);
    assign O_PIN_OE        = I_PORT_DIR;
    assign O_PIN_OUT       = (st.com == COM_OFF) ? I_PORT_DATA : st.ocs;
    assign O_COMPARE_FLAG  = st.cmf;
    assign O_OVERFLOW_FLAG = st.ovf;
    assign O_COMPARE_STATE = st.ocs;

endmodule

`default_nettype wire

/* tmw_timer_asserts.sv */
// Port-level assertions for the waveform timer
`timescale 1ns/1ns
`default_nettype none
module tmw_timer_asserts
    import tmw_pkg::*;
(
    input wire logic                       I_CLOCK,
    input wire logic                       I_RESET,
    input wire logic                       I_PSEL,
    input wire logic                       I_PENABLE,
    input wire logic                       I_PWRITE,
    input wire logic [tmw_pkg::ADDR_W-1:0] I_PADDR,
    input wire logic [tmw_pkg::DATA_W-1:0] I_PWDATA,
    input wire logic                       I_COMPARE_ACK,
    input wire logic                       I_OVERFLOW_ACK,
    input wire logic                       I_PORT_DATA,
    input wire logic                       I_PORT_DIR,
    input wire logic [tmw_pkg::DATA_W-1:0] O_PRDATA,
    input wire logic                       O_PREADY,
    input wire logic                       O_PSLVERR,
    input wire logic                       O_PIN_OUT,
    input wire logic                       O_PIN_OE,
    input wire logic                       O_COMPARE_FLAG,
    input wire logic                       O_OVERFLOW_FLAG,
    input wire logic                       O_COMPARE_STATE
);
    // ************
    // Control shadow
    // ************
    logic [7:0] ctl;
    logic       wr;
    assign wr = I_PSEL & I_PENABLE & I_PWRITE;
    always_ff @(posedge I_CLOCK) begin
        if (I_RESET) begin
            ctl <= 8'h00;
        end else if (wr && I_PADDR == OFF_CONTROL) begin
            ctl <= I_PWDATA[7:0];
        end
    end
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (I_RESET);
    a_pin_dir: assert property (O_PIN_OE == I_PORT_DIR)
        else $error("pin enable differs from direction");
    a_pin_gpio: assert property (ctl[3:2] == COM_OFF |-> O_PIN_OUT == I_PORT_DATA)
        else $error("pin not under port control");
    a_pin_state: assert property (ctl[3:2] != COM_OFF |-> O_PIN_OUT == O_COMPARE_STATE)
        else $error("pin does not show compare state");
    a_ready_high: assert property (O_PREADY)
        else $error("ready low");
    a_err_phase: assert property (O_PSLVERR |-> I_PSEL && I_PENABLE)
        else $error("error outside access phase");
    a_err_unmapped: assert property (I_PSEL && I_PENABLE && I_PADDR > OFF_STATUS |-> O_PSLVERR)
        else $error("unmapped access without error");
    a_flag_hold: assert property (O_COMPARE_FLAG && !I_COMPARE_ACK
        && !(wr && I_PADDR == OFF_FLAGS && I_PWDATA[0]) |=> O_COMPARE_FLAG)
        else $error("match flag lost");
    a_stop_quiet: assert property ((ctl[6:4] == 3'h0) [*2]
        |-> !$rose(O_OVERFLOW_FLAG) && !$rose(O_COMPARE_FLAG))
        else $error("flag set while stopped");
    a_state_quiet: assert property ((ctl[3:0] == {COM_OFF, WGM_MATCH}) [*2]
        |-> $stable(O_COMPARE_STATE))
        else $error("state changed with output mode off");
    c_ovf: cover property ($rose(O_OVERFLOW_FLAG));
    c_err: cover property ($rose(O_PSLVERR));
    c_phase: cover property (ctl[1:0] == WGM_PHASE && $changed(O_COMPARE_STATE));
endmodule
bind tmw_timer tmw_timer_asserts u_chk (.I_CLOCK(I_CLOCK), .I_RESET(I_RESET),
    .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
    .I_PWDATA(I_PWDATA), .I_COMPARE_ACK(I_COMPARE_ACK), .I_OVERFLOW_ACK(I_OVERFLOW_ACK),
    .I_PORT_DATA(I_PORT_DATA), .I_PORT_DIR(I_PORT_DIR), .O_PRDATA(O_PRDATA),
    .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_PIN_OUT(O_PIN_OUT), .O_PIN_OE(O_PIN_OE),
    .O_COMPARE_FLAG(O_COMPARE_FLAG), .O_OVERFLOW_FLAG(O_OVERFLOW_FLAG),
    .O_COMPARE_STATE(O_COMPARE_STATE));
`default_nettype wire
